// File: bench/sbg_asserts.sv
// port checks for the break generator
`timescale 1ns/1ps
`default_nettype none
module sbg_asserts #(parameter int DIV_W = 8) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic break_request,
	input wire logic transmit_enable,
	input wire logic word_length,
	input wire logic [DIV_W-1:0] baud_divider,
	input wire logic serial_tx,
	input wire logic frame_active,
	input wire logic break_active
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	brk_low_a: assert property (break_active |-> !serial_tx) else $error("brk high");
	idle_mark_a: assert property (!break_active |-> serial_tx) else $error("idle low");
	brk_len_a: assert property ($rose(break_active) |-> break_active[*8])
		else $error("brk short");
	brk_one_a: assert property ($fell(break_active) && !break_request |=> !break_active[*3])
		else $error("extra brk");
	brk_rep_a: assert property (break_active && break_request && $stable(transmit_enable)
		|=> break_active) else $error("brk gap");
	idle_first_a: assert property ($rose(transmit_enable) && !frame_active
		|-> ##3 frame_active && serial_tx && !break_active) else $error("no idle");
	off_quiet_a: assert property (!transmit_enable && !frame_active |=> !frame_active)
		else $error("frame while off");
endmodule : sbg_asserts
bind sbg_serial_break_generator sbg_asserts #(.DIV_W(DIV_W)) chk_u (.ref_clk, .nrst,
	.break_request, .transmit_enable, .word_length, .baud_divider, .serial_tx, .frame_active,
	.break_active);
`default_nettype wire

// File: bench/sbg_rx_model.sv
// far receiver timing low runs on the line
`timescale 1ns/1ps
`default_nettype none
module sbg_rx_model (
	input wire logic ref_clk,
	input wire logic serial_tx,
	output logic [7:0] last_len
);
	logic [7:0] run;
	// a run ends at the first mark, so back to back breaks merge
	always_ff @(posedge ref_clk) begin
		run <= serial_tx ? 8'h00 : run + 8'h01;
		if (serial_tx && run != 8'h00) last_len <= run;
	end
endmodule : sbg_rx_model
`default_nettype wire

// File: bench/sbg_serial_break_generator_bench.sv
// bench for break and idle requests
`timescale 1ns/1ps
`default_nettype none
module sbg_serial_break_generator_bench;
	import sbg_pkg::*;
	logic ref_clk = 1'h0, nrst = 1'h0, break_request = 1'h0;
	logic transmit_enable = 1'h0, word_length = 1'h0, serial_tx, frame_active, break_active;
	logic [7:0] baud_divider = 8'h00, last_len;
	int mismatches = 0, checked = 0;
	sbg_serial_break_generator dut_u (.ref_clk, .nrst, .break_request, .transmit_enable,
		.word_length, .baud_divider, .serial_tx, .frame_active, .break_active);
	sbg_rx_model rx_u (.ref_clk, .serial_tx, .last_len);
	initial forever #25 ref_clk = ~ref_clk;
	task automatic wrap_up();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up
	// optional idle, one request, then judge the low run
	task automatic shot(logic wl, logic [7:0] div, int hold, int n, logic idle);
		logic [7:0] e;
		e = 8'(n * (wl ? SBG_FRAME_BITS_LONG : SBG_FRAME_BITS_SHORT) * (div + 1));
		word_length <= wl;
		baud_divider <= div;
		transmit_enable <= !idle;
		@(posedge ref_clk) transmit_enable <= 1'h1;
		@(posedge ref_clk) break_request <= 1'h1;
		repeat (hold) @(posedge ref_clk);
		break_request <= 1'h0;
		repeat (80) @(posedge ref_clk);
		checked++;
		if (last_len !== e) begin
			mismatches++;
			$display("MISMATCH low_run exp %0d seen %0d", e, last_len);
		end
		checked++;
		if (frame_active !== 1'h0 || break_active !== 1'h0) begin
			mismatches++;
			$display("MISMATCH line_busy exp 0 seen %0d%0d", frame_active, break_active);
		end
		$display("test done");
	endtask : shot
	initial begin
		repeat (3) @(posedge ref_clk);
		nrst <= 1'h1;
		repeat (3) @(posedge ref_clk);
		shot(1'h0, 8'h00, 1, 1, 1'h0);
		shot(1'h1, 8'h01, 1, 1, 1'h0);
		shot(1'h0, 8'h00, 15, 2, 1'h0);
		shot(1'h0, 8'h02, 1, 1, 1'h1);
		wrap_up();
	end
	// hang guard, far beyond the four sequences
	initial begin
		repeat (2000) @(posedge ref_clk);
		mismatches++;
		wrap_up();
	end
endmodule : sbg_serial_break_generator_bench
`default_nettype wire

// File: verilog/sbg_pkg.sv
// constants and state codes for the serial break and idle generator
`default_nettype none
package sbg_pkg;
	// frame lengths in bit times
	localparam logic [3:0] SBG_FRAME_BITS_SHORT = 4'hA;
	localparam logic [3:0] SBG_FRAME_BITS_LONG = 4'hB;
	// documented default of the baud divider field width
	localparam int SBG_DIV_WIDTH = 8;
	// line levels
	localparam logic SBG_LINE_MARK = 1'h1;
	localparam logic SBG_LINE_SPACE = 1'h0;
	// reset values
	localparam logic [3:0] SBG_BIT_CNT_RESET = 4'h0;

	typedef enum logic [3:0] {
		SBG_OFF = 4'h1,
		SBG_READY = 4'h2,
		SBG_IDLE = 4'h4,
		SBG_BREAK = 4'h8
	} sbg_state_t;
endpackage : sbg_pkg
`default_nettype wire

// File: verilog/sbg_serial_break_generator.sv
// break and idle frame generator for the serial transmit line
`timescale 1ns/1ps
`default_nettype none
// overview of operation
// four states: off, ready, idle frame, break frame
// off while the transmit enable is low; no frame starts there
// ready waits for a queued idle or a break request
// an idle frame holds the line at mark for one frame length
// a break frame holds the line at space for one frame length
// frame length is 10 or 11 bit times, picked by word_length
// one bit time is baud_divider plus one clock cycles
// the divider restarts at each frame start
// so a break never picks up a stale partial bit from before
// a frame in progress always runs to its end
// so dropping the enable mid frame never cuts a break short
// a rising enable queues one idle frame
// a rising break request queues one break
// a request held high is seen again at every frame end
// so a held request gives breaks back to back with no gap
// a queued idle always goes out before any break
// so the line shows a clean mark ahead of the first break after the enable rises, unless it rises on a break frame's last cycle
// a request taken straight from ready is consumed on that edge
// otherwise the latched copy would send a second break
// all three outputs come straight from flops
// they are loaded from the next state so they line up with it
// limitation: a break request that rises and falls while disabled
// is kept and sent after the queued idle once enabled again
// limitation: word_length is sampled only at frame start
// a change mid frame takes effect on the following frame
// trade-off: one clock of latency from request to line, in return
// for glitch free registered outputs
module sbg_serial_break_generator
	import sbg_pkg::*;
#(
	parameter int DIV_W = SBG_DIV_WIDTH
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic break_request,
	input wire logic transmit_enable,
	input wire logic word_length,
	input wire logic [DIV_W-1:0] baud_divider,
	output logic serial_tx,
	output logic frame_active,
	output logic break_active
);
	// reset synchroniser pair
	logic rst_meta;
	logic rst_n;

	// frame sequencer
	sbg_state_t state;
	sbg_state_t next_state;

	// bit timing
	logic [DIV_W-1:0] div_cnt;
	logic [3:0] bit_cnt;
	logic [3:0] frame_last;

	// request tracking
	logic brk_prev;
	logic te_prev;
	logic break_pending;
	logic idle_pending;
	logic break_taken;

	// frame timing strobes
	logic bit_tick;
	logic frame_end;
	logic frame_start;

	// reset released through two flops, asserted at once
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	assign bit_tick = (div_cnt == baud_divider);
	assign frame_end = (state == SBG_IDLE || state == SBG_BREAK) && bit_tick
		&& (bit_cnt == frame_last);
	assign frame_start = (next_state == SBG_IDLE || next_state == SBG_BREAK)
		&& (state == SBG_READY || frame_end);

	// choose the next frame; idle always ahead of break
	always_comb begin
		next_state = state;
		case (state)
			SBG_OFF: begin
				if (transmit_enable) begin
					next_state = SBG_READY;
				end
			end
			SBG_READY, SBG_IDLE, SBG_BREAK: begin
				if (state == SBG_READY || frame_end) begin
					if (!transmit_enable) begin
						next_state = SBG_OFF;
					end else if (idle_pending) begin
						next_state = SBG_IDLE;
					end else if (break_pending || break_request) begin
						next_state = SBG_BREAK;
					end else begin
						next_state = SBG_READY;
					end
				end
			end
			default: next_state = SBG_OFF;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= SBG_OFF;
		end else begin
			state <= next_state;
		end
	end

	// edge detector on the break request; idles low like its pin
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			brk_prev <= 1'b0;
		end else begin
			brk_prev <= break_request;
		end
	end

	// edge detector on the enable; high at release counts as a rise
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			te_prev <= 1'b0;
		end else begin
			te_prev <= transmit_enable;
		end
	end

	// a break frame starting now consumes the request
	assign break_taken = frame_start && (next_state == SBG_BREAK);

	// a short pulse is caught so it still yields a break, but only one:
	// a rise taken on the very edge it is seen is not kept as well
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			break_pending <= 1'b0;
		end else begin
			break_pending <= ((break_request && !brk_prev) && !break_taken)
				|| (break_pending && !break_taken);
		end
	end

	// enable rising queues one idle; a new edge wins over the clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_pending <= 1'b0;
		end else begin
			idle_pending <= (transmit_enable && !te_prev)
				|| (idle_pending && !(frame_start && next_state == SBG_IDLE));
		end
	end

	// divider restarts with each frame so no stale partial bit stretches it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= '0;
		end else if (frame_start || bit_tick) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + {{(DIV_W-1){1'b0}}, 1'b1};
		end
	end

	// bit position within the frame; wraps harmlessly outside frames
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt <= SBG_BIT_CNT_RESET;
		end else if (frame_start) begin
			bit_cnt <= SBG_BIT_CNT_RESET;
		end else if (bit_tick) begin
			bit_cnt <= bit_cnt + 4'h1;
		end
	end

	// length latched at frame start, later changes wait for next frame
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_last <= SBG_FRAME_BITS_SHORT - 4'h1;
		end else if (frame_start) begin
			frame_last <= (word_length ? SBG_FRAME_BITS_LONG : SBG_FRAME_BITS_SHORT)
				- 4'h1;
		end
	end

	// line driver: space for whole break including stop positions
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_tx <= SBG_LINE_MARK;
		end else begin
			serial_tx <= (next_state == SBG_BREAK) ? SBG_LINE_SPACE : SBG_LINE_MARK;
		end
	end

	// busy flag covers idle and break frames alike
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_active <= 1'b0;
		end else begin
			frame_active <= (next_state == SBG_IDLE) || (next_state == SBG_BREAK);
		end
	end

	// break flag, high exactly while the line is held at space
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			break_active <= 1'b0;
		end else begin
			break_active <= (next_state == SBG_BREAK);
		end
	end
endmodule : sbg_serial_break_generator
`default_nettype wire
